//--- rwsu_core_model.sv
`default_nettype none
module rwsu_core_model
	import rwsu_pkg::*;
(
	input  wire logic       clk,
	input  wire rwsu_resp_t resp,
	output var  rwsu_req_t  req
);
	timeunit 1ns;
	timeprecision 1ps;

	initial req = '0;

	// entered on a falling edge; the answer stands one cycle, so read it at the next one
	task automatic issue(input logic [1:0] c, input logic hold, output rwsu_resp_t r);
		req = '{valid: 1'b1, core: c};
		@(negedge clk) r = resp;
		if (!hold) req = '0; // hold keeps the strobe up for a back-to-back request
	endtask

	// retry while carry is clear, but give up so a dead generator cannot hang the core
	task automatic fetch(input logic [1:0] c, input int limit, output rwsu_resp_t r,
		output int tries);
		r = '0;
		for (tries = 0; tries < limit && r.carry !== 1'b1; tries++) begin
			@(negedge clk);
			issue(c, 1'b0, r);
		end
	endtask
endmodule
`default_nettype wire

//--- rwsu_defines.svh
// What this block does
// R1: identification leaf 01H reports result bit 30 set
// R2: delivered words come from deterministic generator
// R3: generator reseeded often from on-chip entropy
// R4: continuous self test tags bad output
// R5: bad-tagged output yields no data
// R6: supply shortfall completes with carry flag clear
// R7: valid word completes with carry flag set
// R8: requester retries while carry flag is clear
// R9: requester bounds its retries with a limit
// R10: one completion per request, zero word when invalid
`ifndef RWSU_DEFINES_SVH
`define RWSU_DEFINES_SVH

`define RWSU_WORD_W       64
`define RWSU_CORE_W       2
`define RWSU_LEAF_W       32
`define RWSU_ID_LEAF      32'h0000_0001
`define RWSU_ID_BIT       30
`define RWSU_GEN_CYCLES   4
`define RWSU_RESEED_WORDS 16
`define RWSU_POOL_BITS    64
`define RWSU_REP_LIMIT    24
`define RWSU_SEED_INIT    64'h0123_4567_89ab_cdef
`define RWSU_GOLDEN       64'h9e37_79b9_7f4a_7c15
`define RWSU_MIX_A        64'hbf58_476d_1ce4_e5b9
`define RWSU_MIX_B        64'h94d0_49bb_1331_11eb

`endif

//--- rwsu_pkg.sv
`include "rwsu_defines.svh"
`default_nettype none
package rwsu_pkg;
	// one request from a core executing the random fetch
	typedef struct packed {
		logic                      valid;
		logic [`RWSU_CORE_W-1:0]   core;
	} rwsu_req_t;

	// one completion back to the requesting core
	typedef struct packed {
		logic                      valid;
		logic                      carry;
		logic [`RWSU_CORE_W-1:0]   core;
		logic [`RWSU_WORD_W-1:0]   word;
	} rwsu_resp_t;
endpackage
`default_nettype wire

//--- rwsu_rep_test.sv
`include "rwsu_defines.svh"
`default_nettype none
module rwsu_rep_test #(
	parameter int REP_LIMIT = `RWSU_REP_LIMIT
) (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic bitValid,
	input  wire logic bitIn,
	output var  logic fail
);
	localparam int CW = $clog2(REP_LIMIT + 1);

	logic          lastBit;
	logic [CW-1:0] runLen;
	logic          next_lastBit;
	logic [CW-1:0] next_runLen;
	logic          next_fail;

	// a stuck noise source shows as a long run of one value
	always_comb begin
		next_lastBit = lastBit;
		next_runLen  = runLen;
		next_fail    = 1'b0;
		if (bitValid) begin
			next_lastBit = bitIn;
			if (bitIn == lastBit && runLen != CW'(REP_LIMIT)) begin
				next_runLen = runLen + CW'(1);
			end else if (bitIn != lastBit) begin
				next_runLen = CW'(1);
			end
			next_fail = (bitIn == lastBit) && (runLen >= CW'(REP_LIMIT - 1)); // R4
		end
	end

	// registers only
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lastBit <= 1'b0;
			runLen  <= '0;
			fail    <= 1'b0;
		end else begin
			lastBit <= next_lastBit;
			runLen  <= next_runLen;
			fail    <= next_fail;
		end
	end
endmodule
`default_nettype wire

//--- rwsu_top.sv
`include "rwsu_defines.svh"
`default_nettype none
module rwsu_top
	import rwsu_pkg::*;
#(
	parameter int GEN_CYCLES   = `RWSU_GEN_CYCLES,
	parameter int RESEED_WORDS = `RWSU_RESEED_WORDS,
	parameter int POOL_BITS    = `RWSU_POOL_BITS,
	parameter int REP_LIMIT    = `RWSU_REP_LIMIT
) (
	input  wire logic                    clk,
	input  wire logic                    rst_n,
	input  wire logic                    entValid,
	input  wire logic                    entBit,
	input  wire rwsu_req_t               req,
	output var  rwsu_resp_t              resp,
	input  wire logic                    queryValid,
	input  wire logic [`RWSU_LEAF_W-1:0] queryLeaf,
	output var  logic                    queryDone,
	output var  logic [`RWSU_LEAF_W-1:0] identificationResultReg,
	output var  logic                    healthAlarm
);
	localparam int W  = `RWSU_WORD_W;
	localparam int TW = $clog2(GEN_CYCLES + 1);
	localparam int SW = $clog2(RESEED_WORDS + 1);
	localparam int PW = $clog2(POOL_BITS + 1);

	logic          repFail;
	logic [W-1:0]  genState;
	logic [W-1:0]  pool;
	logic [PW-1:0] poolCount;
	logic          poolTaint;
	logic          seedBad;
	logic          seeded;
	logic [TW-1:0] genTimer;
	logic [SW-1:0] wordsSinceSeed;
	logic          slotFull;
	logic          slotBad;
	logic [W-1:0]  slotWord;
	logic [W-1:0]  prevWord;
	logic          afterReseed;

	logic [W-1:0]  next_genState;
	logic [W-1:0]  next_pool;
	logic [PW-1:0] next_poolCount;
	logic          next_poolTaint;
	logic          next_seedBad;
	logic          next_seeded;
	logic [TW-1:0] next_genTimer;
	logic [SW-1:0] next_wordsSinceSeed;
	logic          next_slotFull;
	logic          next_slotBad;
	logic [W-1:0]  next_slotWord;
	logic [W-1:0]  next_prevWord;
	logic          next_afterReseed;
	rwsu_resp_t    next_resp;
	logic          next_queryDone;
	logic [`RWSU_LEAF_W-1:0] next_idResult;
	logic          next_healthAlarm;

	logic          reseed;
	logic          fill;
	logic [W-1:0]  genWord;
	logic          lateFail;

	// raw entropy is only ever a seed, never handed out directly
	rwsu_rep_test #(
		.REP_LIMIT (REP_LIMIT)
	) u_rep_test (
		.clk      (clk),
		.rst_n    (rst_n),
		.bitValid (entValid),
		.bitIn    (entBit),
		.fail     (repFail)
	);

	// nonlinear output mix; the multiplies cost area but hide the state
	function automatic logic [W-1:0] mixWord(input logic [W-1:0] s);
		logic [W-1:0] z;
		z = s;
		z = (z ^ (z >> 30)) * `RWSU_MIX_A;
		z = (z ^ (z >> 27)) * `RWSU_MIX_B;
		return z ^ (z >> 31);
	endfunction

	assign reseed  = entValid && (poolCount == PW'(POOL_BITS - 1));
	assign fill    = (genTimer == '0) && !slotFull;
	assign genWord = mixWord(genState + `RWSU_GOLDEN); // R2
	// the repetition verdict lags its bit by one clock, so a failure seen just
	// after a reseed belongs to the pool that was just folded in, not the new one
	assign lateFail = afterReseed && repFail; // R4

	// seed pool, generator state and the single output slot
	always_comb begin
		next_genState       = genState;
		next_pool           = pool;
		next_poolCount      = poolCount;
		next_poolTaint      = poolTaint | (repFail && !afterReseed); // R4
		next_seedBad        = seedBad;
		next_seeded         = seeded;
		next_genTimer       = (genTimer == '0) ? TW'(GEN_CYCLES - 1) : genTimer - TW'(1);
		next_wordsSinceSeed = wordsSinceSeed;
		next_slotFull       = slotFull;
		next_slotBad        = slotBad;
		next_slotWord       = slotWord;
		next_prevWord       = prevWord;
		next_afterReseed    = reseed;
		if (entValid) begin
			next_pool      = {pool[W-2:0], entBit};
			next_poolCount = poolCount + PW'(1);
		end
		if (fill) begin
			next_genState = genState + `RWSU_GOLDEN;
			next_slotWord = genWord;
			next_prevWord = genWord;
			next_slotFull = 1'b1;
			// stale seed, tainted seed or a repeated word all count as bad
			next_slotBad  = seedBad || !seeded || (genWord == prevWord)
				|| (wordsSinceSeed >= SW'(RESEED_WORDS)) || lateFail; // R4
			if (wordsSinceSeed != SW'(RESEED_WORDS)) begin
				next_wordsSinceSeed = wordsSinceSeed + SW'(1);
			end
		end
		if (lateFail) begin
			// the seed just taken is bad after all; distrust whatever waits in the slot
			next_seedBad = 1'b1; // R4
			next_slotBad = 1'b1; // R5
		end
		if (reseed) begin
			// fold the fresh pool into the state; a reseed outranks a fill
			next_genState       = mixWord(next_genState ^ next_pool); // R3
			next_poolCount      = '0;
			next_poolTaint      = 1'b0;
			next_seedBad        = poolTaint | repFail;
			next_seeded         = seeded | !(poolTaint | repFail);
			if (poolTaint | repFail) begin
				next_slotBad = 1'b1; // R5
			end
			next_wordsSinceSeed = '0;
		end
		if (req.valid && slotFull) begin
			next_slotFull = 1'b0; // bad words are dropped too
		end
	end

	// completion and identification answers
	always_comb begin
		next_resp       = '0; // R6
		next_resp.valid = req.valid; // R10
		next_resp.core  = req.core;
		if (req.valid && slotFull && !slotBad) begin // R5
			next_resp.carry = 1'b1; // R7
			next_resp.word  = slotWord;
		end
		// empty or bad slot: carry clear and zero word
		next_queryDone   = queryValid;
		next_idResult    = '0;
		if (queryValid && queryLeaf == `RWSU_ID_LEAF) begin
			next_idResult[`RWSU_ID_BIT] = 1'b1; // R1
		end
		next_healthAlarm = next_seedBad;
	end

	// registers only
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			genState                <= `RWSU_SEED_INIT;
			pool                    <= '0;
			poolCount               <= '0;
			poolTaint               <= 1'b0;
			seedBad                 <= 1'b0;
			seeded                  <= 1'b0;
			genTimer                <= '0;
			wordsSinceSeed          <= '0;
			slotFull                <= 1'b0;
			slotBad                 <= 1'b1;
			slotWord                <= '0;
			prevWord                <= '0;
			afterReseed             <= 1'b0;
			resp                    <= '0;
			queryDone               <= 1'b0;
			identificationResultReg <= '0;
			healthAlarm             <= 1'b0;
		end else begin
			genState                <= next_genState;
			pool                    <= next_pool;
			poolCount               <= next_poolCount;
			poolTaint               <= next_poolTaint;
			seedBad                 <= next_seedBad;
			seeded                  <= next_seeded;
			genTimer                <= next_genTimer;
			wordsSinceSeed          <= next_wordsSinceSeed;
			slotFull                <= next_slotFull;
			slotBad                 <= next_slotBad;
			slotWord                <= next_slotWord;
			prevWord                <= next_prevWord;
			afterReseed             <= next_afterReseed;
			resp                    <= next_resp;
			queryDone               <= next_queryDone;
			identificationResultReg <= next_idResult;
			healthAlarm             <= next_healthAlarm;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence takeGood;
		req.valid && slotFull && !slotBad;
	endsequence

	sequence takeEmpty;
		req.valid && !slotFull;
	endsequence

	id_bit_set_a: assert property ( // R1
		queryValid && queryLeaf == `RWSU_ID_LEAF |=> queryDone && identificationResultReg[30])
		else $error("identification bit missing");
	id_bit_other_a: assert property ( // R1
		queryValid && queryLeaf != `RWSU_ID_LEAF |=> identificationResultReg == '0)
		else $error("identification bit on wrong leaf");
	good_delivered_a: assert property ( // R7
		takeGood |=> resp.valid && resp.carry && resp.word == $past(slotWord))
		else $error("good word not delivered with carry");
	bad_blocked_a: assert property ( // R5
		req.valid && slotFull && slotBad |=> resp.valid && !resp.carry && resp.word == '0)
		else $error("bad word passed on");
	underflow_clear_a: assert property ( // R6
		takeEmpty |=> resp.valid && !resp.carry)
		else $error("empty slot answered with carry");
	one_answer_a: assert property ( // R10
		req.valid |=> resp.valid && resp.core == $past(req.core))
		else $error("request not answered once");
	no_spurious_a: assert property ( // R10
		!req.valid |=> !resp.valid)
		else $error("completion without request");
	nodata_zero_a: assert property ( // R10
		resp.valid && !resp.carry |-> resp.word == '0)
		else $error("no-data completion with nonzero word");
	slot_consumed_a: assert property ( // R5
		req.valid && slotFull |=> !slotFull && resp.valid)
		else $error("slot not emptied by request");
	reseed_count_a: assert property ( // R3
		reseed |=> wordsSinceSeed == '0 && poolCount == '0)
		else $error("reseed did not restart counters");
	stale_bad_a: assert property ( // R4
		fill && !reseed && wordsSinceSeed >= SW'(RESEED_WORDS) |=> slotFull && slotBad)
		else $error("stale generator output not tagged bad");
	repeat_bad_a: assert property ( // R4
		fill && genWord == prevWord |=> slotBad)
		else $error("repeated word not tagged bad");
endmodule
`default_nettype wire

//--- testbench.sv
`default_nettype none
module testbench;
	import rwsu_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int GEN = 4;
	localparam int POOL = 8;
	localparam int RESEED = 16;
	logic        clk, rst_n, entValid, entBit, queryValid, queryDone, healthAlarm;
	logic [31:0] queryLeaf, idResult;
	rwsu_req_t   req;
	rwsu_resp_t  resp;
	int          errCount, compares;

	rwsu_top #(.GEN_CYCLES(GEN), .RESEED_WORDS(RESEED), .POOL_BITS(POOL), .REP_LIMIT(4))
	rwsu_top_inst (.clk(clk), .rst_n(rst_n), .entValid(entValid), .entBit(entBit),
		.req(req), .resp(resp), .queryValid(queryValid), .queryLeaf(queryLeaf),
		.queryDone(queryDone), .identificationResultReg(idResult),
		.healthAlarm(healthAlarm));
	rwsu_core_model rwsu_core_model_inst (.clk(clk), .resp(resp), .req(req));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic check(input string what, input logic [63:0] got, input logic [63:0] exp);
		compares++;
		if (got !== exp) begin
			errCount++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic complete_run();
		if (errCount == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// one pool of entropy, then time for the repetition test, reseed and a slot refill
	task automatic feed(input logic [7:0] bits);
		for (int i = 0; i < POOL; i++) begin
			@(negedge clk);
			entValid = 1'b1;
			entBit = bits[i];
		end
		@(negedge clk) entValid = 1'b0;
		repeat (3 * GEN) @(negedge clk);
	endtask

	// before any reseed the unit must answer, but with no data
	task automatic t_unseeded();
		rwsu_resp_t r;
		int n;
		rwsu_core_model_inst.fetch(2'd1, 1, r, n);
		check("unseeded valid", 64'(r.valid), 64'h1);
		check("unseeded carry", 64'(r.carry), 64'h0);
		check("unseeded word", r.word, 64'h0);
		check("unseeded core", 64'(r.core), 64'h1);
	endtask

	// only leaf one advertises the random fetch
	task automatic t_query();
		logic [31:0] leaves [4] = '{32'h0000_0001, 32'h0000_0000, 32'h0000_0002, 32'h8000_0001};
		foreach (leaves[i]) begin
			@(negedge clk);
			queryValid = 1'b1;
			queryLeaf = leaves[i];
			@(negedge clk);
			check("query done", 64'(queryDone), 64'h1);
			check("query result", 64'(idResult),
				(leaves[i] == 32'h0000_0001) ? 64'h4000_0000 : 64'h0);
			queryValid = 1'b0;
		end
	endtask

	// clean seed: retry gets a word, then a back-to-back pair drains the single slot
	task automatic t_seeded();
		rwsu_resp_t r, r1, r2;
		int n;
		feed(8'h5a);
		check("alarm clean", 64'(healthAlarm), 64'h0);
		rwsu_core_model_inst.fetch(2'd3, 4, r, n);
		check("fetch carry", 64'(r.carry), 64'h1);
		check("fetch nonzero", 64'(r.word != 64'h0), 64'h1);
		repeat (2 * GEN) @(negedge clk);
		rwsu_core_model_inst.issue(2'd2, 1'b1, r1);
		rwsu_core_model_inst.issue(2'd2, 1'b0, r2);
		check("first carry", 64'(r1.carry), 64'h1);
		check("first core", 64'(r1.core), 64'h2);
		check("new word", 64'(r1.word != r.word), 64'h1);
		check("second valid", 64'(r2.valid), 64'h1);
		check("second carry", 64'(r2.carry), 64'h0);
		check("second word", r2.word, 64'h0);
		@(negedge clk);
		check("answer stands once", 64'(resp.valid), 64'h0);
	endtask

	// stuck entropy taints the seed: no data until a clean reseed
	task automatic t_tainted();
		rwsu_resp_t r;
		int n;
		feed(8'hff);
		check("alarm raised", 64'(healthAlarm), 64'h1);
		rwsu_core_model_inst.fetch(2'd0, 3, r, n);
		check("bad carry", 64'(r.carry), 64'h0);
		check("bad word", r.word, 64'h0);
		check("retries bounded", 64'(n), 64'h3);
		feed(8'h5a);
		check("alarm cleared", 64'(healthAlarm), 64'h0);
		rwsu_core_model_inst.fetch(2'd1, 4, r, n);
		check("recovered carry", 64'(r.carry), 64'h1);
	endtask

	// one seed serves a bounded number of words; later ones come back with no data
	task automatic t_stale();
		rwsu_resp_t r;
		feed(8'h5a);
		rwsu_core_model_inst.issue(2'd1, 1'b0, r); // drains the word made before the reseed
		for (int i = 0; i < RESEED + 2; i++) begin
			repeat (GEN) @(negedge clk);
			rwsu_core_model_inst.issue(2'd1, 1'b0, r);
			if (i < RESEED) begin
				check("fresh carry", 64'(r.carry), 64'h1);
			end else begin
				check("stale carry", 64'(r.carry), 64'h0);
				check("stale word", r.word, 64'h0);
			end
		end
	endtask

	// a hang is cut short and counted
	initial begin
		repeat (20000) @(posedge clk);
		errCount++;
		complete_run();
	end

	initial begin
		errCount = 0;
		compares = 0;
		rst_n = 1'b0;
		entValid = 1'b0;
		entBit = 1'b0;
		queryValid = 1'b0;
		queryLeaf = 32'h0000_0000;
		repeat (12) @(negedge clk);
		check("reset resp", 64'(resp.valid), 64'h0);
		check("reset done", 64'(queryDone), 64'h0);
		rst_n = 1'b1;
		t_unseeded();
		t_query();
		t_seeded();
		t_tainted();
		t_stale();
		complete_run();
	end
endmodule
`default_nettype wire
